/* verilog/nip_top.sv */
// node identity and phy register access registers of the link layer
// assumes a simple register port (one access per cycle) and phy pins
// Notes on behaviour
// RULE1: node id is bus segment then node index
// RULE2: valid clears on bus reset, sets on index
// RULE3: root flag follows phy root report
// RULE4: cable power bit follows phy report
// RULE5: node identity reserved bits read zero
// RULE6: bus segment writable, resets to all ones
// RULE7: node index loaded from phy, not writable
// RULE8: software avoids dma run when index 63
// RULE9: request write clears read-complete flag
// RULE10: any phy register transfer sets read-complete
// RULE11: capture returned register index
// RULE12: capture returned register value
// RULE13: read request bit self-clears once sent
// RULE14: write request bit self-clears once sent
// RULE15: software never sets both request bits
// RULE16: target index selects phy register
// RULE17: write value sent only for writes
// RULE18: phy access reserved bits read zero
// RULE19: requests go out on link request line
// RULE20: index, value and flag update together
`timescale 1ns/1ps
module nip_top
    import nip_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic [1:0] phy_ctl,
    input wire logic [1:0] phy_d,
    output logic phy_lreq,
    output logic [15:0] node_id,
    output logic node_id_valid,
    output logic node_index_none
);
    import nip_pkg::*;

    // node identity state
    logic valid_q;
    logic root_q;
    logic cps_q;
    logic [NIP_NI_BUS_W-1:0] bus_seg_q;
    logic [NIP_NI_NODE_W-1:0] node_idx_q;

    // phy access state
    logic done_q;
    logic [3:0] ret_index_q;
    logic [7:0] ret_value_q;
    logic rd_req_q;
    logic wr_req_q;
    logic [3:0] target_index_q;
    logic [7:0] write_value_q;
    logic launch_q;

    // helper wires
    logic wr_node;
    logic wr_phy;
    logic sw_req;
    logic bus_reset;
    logic xfer_valid;
    nip_phy_xfer_t xfer;
    logic tx_busy;
    logic tx_done;
    logic tx_lreq;
    nip_phy_req_t tx_req;
    logic id_xfer;
    logic [31:0] node_word;
    logic [31:0] phy_word;

    assign wr_node = reg_wr && (reg_addr == NIP_OFF_NODE_IDENTITY);
    assign wr_phy = reg_wr && (reg_addr == NIP_OFF_PHY_REG_ACCESS);
    assign sw_req = wr_phy && (reg_wdata[NIP_PA_RDREQ_BIT] ||
        reg_wdata[NIP_PA_WRREQ_BIT]);
    assign id_xfer = xfer_valid && (xfer.index == NIP_PHY_REG_ID);

    nip_status_rx u_rx (
        .core_clk(core_clk),
        .nrst(nrst),
        .ce(ce),
        .phy_ctl(phy_ctl),
        .phy_d(phy_d),
        .bus_reset(bus_reset),
        .xfer_valid(xfer_valid),
        .xfer(xfer)
    );

    // a read wins if software breaks the one-request-at-a-time contract
    assign tx_req.is_write = wr_req_q && !rd_req_q; // RULE15
    assign tx_req.index = target_index_q; // RULE16
    assign tx_req.value = write_value_q; // RULE17

    nip_lreq_tx u_tx (
        .core_clk(core_clk),
        .nrst(nrst),
        .ce(ce),
        .start(launch_q),
        .req(tx_req),
        .busy(tx_busy),
        .done(tx_done),
        .lreq(tx_lreq)
    );

    // node identity valid flag
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            valid_q <= 1'b0;
        end else if (ce) begin
            if (bus_reset)
                valid_q <= 1'b0; // RULE2
            else if (id_xfer)
                valid_q <= 1'b1; // RULE2
        end
    end

    // root flag comes from phy register 0
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            root_q <= 1'b0;
        end else if (ce) begin
            if (id_xfer)
                root_q <= xfer.value[NIP_PHY_ROOT_BIT]; // RULE3
        end
    end

    // cable power only changes on a register 0 transfer
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cps_q <= 1'b0;
        end else if (ce) begin
            if (id_xfer)
                cps_q <= xfer.value[NIP_PHY_CPS_BIT]; // RULE4
        end
    end

    // node index has no software path; only the phy loads it
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            node_idx_q <= NIP_NODE_INDEX_RESET;
        end else if (ce) begin
            if (id_xfer)
                node_idx_q <= xfer.value[7:NIP_PHY_ID_LSB]; // RULE7
        end
    end

    // bus segment number, the only software-written node identity field
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            bus_seg_q <= NIP_BUS_SEG_RESET; // RULE6
        end else if (ce) begin
            if (wr_node)
                bus_seg_q <= reg_wdata[15:NIP_NI_BUS_LSB]; // RULE6
        end
    end

    // read-complete flag: a transfer in the same cycle beats the clear
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            done_q <= 1'b0;
        end else if (ce) begin
            if (xfer_valid)
                done_q <= 1'b1; // RULE10
            else if (sw_req)
                done_q <= 1'b0; // RULE9
        end
    end

    // returned index and value load in the cycle the flag sets; a clear leaves them
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ret_index_q <= 4'h0;
        end else if (ce) begin
            if (xfer_valid)
                ret_index_q <= xfer.index; // RULE11 RULE20
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ret_value_q <= 8'h00;
        end else if (ce) begin
            if (xfer_valid)
                ret_value_q <= xfer.value; // RULE12 RULE20
        end
    end

    // target index and write value are latched at every access write
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            target_index_q <= 4'h0;
        end else if (ce) begin
            if (wr_phy)
                target_index_q <= reg_wdata[11:NIP_PA_TADDR_LSB];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            write_value_q <= 8'h00;
        end else if (ce) begin
            if (wr_phy)
                write_value_q <= reg_wdata[7:NIP_PA_WDATA_LSB];
        end
    end

    // request bits: set by software, cleared when the frame has gone out.
    // a new software set in the same cycle as the end of a frame is kept.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rd_req_q <= 1'b0;
        end else if (ce) begin
            if (wr_phy && reg_wdata[NIP_PA_RDREQ_BIT])
                rd_req_q <= 1'b1;
            else if (tx_done)
                rd_req_q <= 1'b0; // RULE13
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            wr_req_q <= 1'b0;
        end else if (ce) begin
            if (wr_phy && reg_wdata[NIP_PA_WRREQ_BIT])
                wr_req_q <= 1'b1;
            else if (tx_done)
                wr_req_q <= 1'b0; // RULE14
        end
    end

    // one launch per pending request; the frame's busy holds off the next
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            launch_q <= 1'b0;
        end else if (ce) begin
            launch_q <= (rd_req_q || wr_req_q) && !tx_busy && !launch_q &&
                !tx_done; // RULE19
        end
    end

    always_comb begin
        node_word = 32'h00000000; // RULE5
        node_word[NIP_NI_VALID_BIT] = valid_q;
        node_word[NIP_NI_ROOT_BIT] = root_q;
        node_word[NIP_NI_CPS_BIT] = cps_q;
        node_word[15:0] = {bus_seg_q, node_idx_q}; // RULE1
    end

    always_comb begin
        phy_word = 32'h00000000; // RULE18
        phy_word[NIP_PA_DONE_BIT] = done_q;
        phy_word[27:NIP_PA_RADDR_LSB] = ret_index_q;
        phy_word[23:NIP_PA_RDATA_LSB] = ret_value_q;
        phy_word[NIP_PA_RDREQ_BIT] = rd_req_q;
        phy_word[NIP_PA_WRREQ_BIT] = wr_req_q;
        phy_word[11:NIP_PA_TADDR_LSB] = target_index_q;
        phy_word[7:NIP_PA_WDATA_LSB] = write_value_q;
    end

    // registered read port; other addresses answer zero
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            reg_rdata <= 32'h00000000;
        end else if (ce) begin
            if (reg_rd) begin
                unique case (reg_addr)
                    NIP_OFF_NODE_IDENTITY: reg_rdata <= node_word;
                    NIP_OFF_PHY_REG_ACCESS: reg_rdata <= phy_word;
                    default: reg_rdata <= 32'h00000000;
                endcase
            end
        end
    end

    // status outputs registered so they come straight from flops;
    // this costs one cycle of latency on the request line
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            phy_lreq <= 1'b0;
        end else if (ce) begin
            phy_lreq <= tx_lreq;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            node_id <= {NIP_BUS_SEG_RESET, NIP_NODE_INDEX_RESET};
        end else if (ce) begin
            node_id <= {bus_seg_q, node_idx_q}; // RULE1
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            node_id_valid <= 1'b0;
        end else if (ce) begin
            node_id_valid <= valid_q;
        end
    end

    // software must not run the transmit dma while this is high
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            node_index_none <= 1'b0;
        end else if (ce) begin
            node_index_none <= (node_idx_q == NIP_NODE_INDEX_NONE); // RULE8
        end
    end
endmodule

/* verilog/nip_pkg.sv */
// package for the node identity and phy register access block
// assumes one core clock; shared by the top and its two helpers
package nip_pkg;

    // register offsets (byte addresses)
    localparam logic [7:0] NIP_OFF_NODE_IDENTITY = 8'he8;
    localparam logic [7:0] NIP_OFF_PHY_REG_ACCESS = 8'hec;

    // node identity layout
    localparam int NIP_NI_VALID_BIT = 31;
    localparam int NIP_NI_ROOT_BIT = 30;
    localparam int NIP_NI_CPS_BIT = 27;
    localparam int NIP_NI_BUS_LSB = 6;
    localparam int NIP_NI_BUS_W = 10;
    localparam int NIP_NI_NODE_W = 6;
    localparam logic [9:0] NIP_BUS_SEG_RESET = 10'h3ff;
    localparam logic [5:0] NIP_NODE_INDEX_RESET = 6'h00;
    localparam logic [5:0] NIP_NODE_INDEX_NONE = 6'h3f;

    // phy register access layout
    localparam int NIP_PA_DONE_BIT = 31;
    localparam int NIP_PA_RADDR_LSB = 24;
    localparam int NIP_PA_RDATA_LSB = 16;
    localparam int NIP_PA_RDREQ_BIT = 15;
    localparam int NIP_PA_WRREQ_BIT = 14;
    localparam int NIP_PA_TADDR_LSB = 8;
    localparam int NIP_PA_WDATA_LSB = 0;

    // phy register 0 holds the physical id, root and cable power bits
    localparam logic [3:0] NIP_PHY_REG_ID = 4'h0;
    localparam int NIP_PHY_ID_LSB = 2;
    localparam int NIP_PHY_ROOT_BIT = 1;
    localparam int NIP_PHY_CPS_BIT = 0;

    // link request line: start bit, 3-bit type, address, data, stop bit
    localparam logic [2:0] NIP_LREQ_READ = 3'h4;
    localparam logic [2:0] NIP_LREQ_WRITE = 3'h5;
    localparam logic [4:0] NIP_LREQ_LEN_READ = 5'h09;
    localparam logic [4:0] NIP_LREQ_LEN_WRITE = 5'h11;

    // status transfer: ctl code and pair count
    localparam logic [1:0] NIP_CTL_STATUS = 2'h1;
    localparam logic [3:0] NIP_STATUS_PAIRS = 4'h8;

    typedef struct packed {
        logic is_write;
        logic [3:0] index;
        logic [7:0] value;
    } nip_phy_req_t;

    typedef struct packed {
        logic [3:0] index;
        logic [7:0] value;
    } nip_phy_xfer_t;

endpackage

/* verilog/nip_lreq_tx.sv */
// serialiser for register read/write requests on the link request line
// assumes start only while busy is low; one bit per core clock
`timescale 1ns/1ps
module nip_lreq_tx
    import nip_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic start,
    input nip_pkg::nip_phy_req_t req,
    output logic busy,
    output logic done,
    output logic lreq
);
    logic [16:0] shift_q;
    logic [4:0] left_q;

    assign busy = (left_q != 5'h00);

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            shift_q <= 17'h00000;
            left_q <= 5'h00;
            lreq <= 1'b0;
            done <= 1'b0;
        end else if (ce) begin
            done <= 1'b0;
            if (start && !busy) begin
                // frame sent msb first; a read carries no data byte
                if (req.is_write) begin
                    shift_q <= {1'b1, NIP_LREQ_WRITE, req.index, req.value,
                        1'b0};
                    left_q <= NIP_LREQ_LEN_WRITE;
                end else begin
                    shift_q <= {1'b1, NIP_LREQ_READ, req.index, 1'b0,
                        8'h00};
                    left_q <= NIP_LREQ_LEN_READ;
                end
            end else if (busy) begin
                lreq <= shift_q[16];
                shift_q <= {shift_q[15:0], 1'b0};
                left_q <= left_q - 5'h01;
                done <= (left_q == 5'h01);
            end else begin
                lreq <= 1'b0;
            end
        end
    end
endmodule

/* verilog/nip_status_rx.sv */
// receiver for phy status transfers on ctl/d pins
// assumes the pins are asynchronous; two flops precede any decode
`timescale 1ns/1ps
module nip_status_rx
    import nip_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [1:0] phy_ctl,
    input wire logic [1:0] phy_d,
    output logic bus_reset,
    output logic xfer_valid,
    output nip_pkg::nip_phy_xfer_t xfer
);
    logic [3:0] meta_q;
    logic [3:0] sync_q;
    logic [15:0] bits_q;
    logic [3:0] pairs_q;
    logic in_status;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            meta_q <= 4'h0;
            sync_q <= 4'h0;
        end else if (ce) begin
            meta_q <= {phy_ctl, phy_d};
            sync_q <= meta_q;
        end
    end

    assign in_status = (sync_q[3:2] == NIP_CTL_STATUS);

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            bits_q <= 16'h0000;
            pairs_q <= 4'h0;
            bus_reset <= 1'b0;
            xfer_valid <= 1'b0;
            xfer <= '0;
        end else if (ce) begin
            bus_reset <= 1'b0;
            xfer_valid <= 1'b0;
            if (in_status) begin
                // pair k carries status bit 2k on d0 and 2k+1 on d1
                bits_q <= {bits_q[13:0], sync_q[0], sync_q[1]};
                if (pairs_q != 4'hf)
                    pairs_q <= pairs_q + 4'h1;
                bus_reset <= (pairs_q == 4'h1) && sync_q[0];
            end else begin
                pairs_q <= 4'h0;
                // only a full 16-bit status carries a register
                if (pairs_q == NIP_STATUS_PAIRS) begin
                    xfer_valid <= 1'b1;
                    xfer.index <= bits_q[11:8];
                    xfer.value <= bits_q[7:0];
                end
            end
        end
    end
endmodule

/* tb/nip_top_props.sv */
// checker for the node identity and phy access block
// assumes binding to nip_top; one clock, sync active-low reset
`timescale 1ns/1ps
module nip_top_props (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic [1:0] phy_ctl,
    input wire logic [1:0] phy_d,
    input wire logic phy_lreq,
    input wire logic [15:0] node_id,
    input wire logic node_id_valid,
    input wire logic node_index_none
);
    logic rd_ni;
    logic rd_pa;
    logic wr_ni;
    logic wr_pa;
    assign rd_ni = ce && reg_rd && reg_addr == 8'he8;
    assign rd_pa = ce && reg_rd && reg_addr == 8'hec;
    assign wr_ni = ce && reg_wr && reg_addr == 8'he8;
    assign wr_pa = ce && reg_wr && reg_addr == 8'hec;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    property p_rst;
        disable iff (1'b0) !nrst && ce |=> reg_rdata == 32'h0
            && !phy_lreq && node_id == 16'hffc0 && !node_id_valid;
    endproperty
    property p_ni_rd;
        rd_ni |=> reg_rdata[15:0] == node_id
            && reg_rdata[31] == node_id_valid;
    endproperty
    property p_ni_rsv;
        rd_ni |=> reg_rdata[29:28] == 2'h0 && reg_rdata[26:16] == 11'h0;
    endproperty
    property p_pa_rsv;
        rd_pa |=> reg_rdata[30:28] == 3'h0 && reg_rdata[13:12] == 2'h0;
    endproperty
    property p_none;
        node_index_none == (node_id[5:0] == 6'h3f);
    endproperty
    property p_idx_ro;
        wr_ni |=> $stable(node_id[5:0]) ##1 $stable(node_id[5:0]);
    endproperty
    property p_bus_wr;
        wr_ni |=> ##1 node_id[15:6] == $past(reg_wdata[15:6], 2);
    endproperty
    // idle for four cycles, then start bit and type 100 or 101
    property p_rd_frame;
        wr_pa && reg_wdata[15] |=> !phy_lreq [*4] ##1 phy_lreq
            ##1 phy_lreq ##1 !phy_lreq ##1 !phy_lreq;
    endproperty
    property p_wr_frame;
        wr_pa && reg_wdata[14] && !reg_wdata[15] |=> !phy_lreq [*4]
            ##1 phy_lreq ##1 phy_lreq ##1 !phy_lreq ##1 phy_lreq;
    endproperty
    a_rst: assert property (p_rst) else $error("bad reset");
    a_ni_rd: assert property (p_ni_rd) else $error("node id");
    a_ni_rsv: assert property (p_ni_rsv) else $error("ni rsv");
    a_pa_rsv: assert property (p_pa_rsv) else $error("pa rsv");
    a_none: assert property (p_none) else $error("none flag");
    a_idx_ro: assert property (p_idx_ro) else $error("idx wr");
    a_bus_wr: assert property (p_bus_wr) else $error("bus wr");
    a_rd_frame: assert property (p_rd_frame) else $error("rd");
    a_wr_frame: assert property (p_wr_frame) else $error("wr");
    c_rd: cover property (wr_pa && reg_wdata[15]);
    c_wr: cover property (wr_pa && reg_wdata[14]);
    c_vld: cover property ($rose(node_id_valid));
endmodule
bind nip_top nip_top_props i_props (
    .core_clk(core_clk),
    .nrst(nrst),
    .ce(ce),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .phy_ctl(phy_ctl),
    .phy_d(phy_d),
    .phy_lreq(phy_lreq),
    .node_id(node_id),
    .node_id_valid(node_id_valid),
    .node_index_none(node_index_none)
);

/* tb/nip_phy_model.sv */
// phy side model: sends status transfers, collects request frames
// assumes the bench calls send(); one lreq bit per core clock
`timescale 1ns/1ps
module nip_phy_model (
    input wire logic core_clk,
    input wire logic phy_lreq,
    output logic [1:0] phy_ctl,
    output logic [1:0] phy_d
);
    logic [16:0] frame;
    logic [16:0] sh;
    logic [4:0] n = 5'h0;
    logic is_wr = 1'b0;
    int got = 0;
    initial begin
        phy_ctl = 2'h0;
        phy_d = 2'h0;
    end
    task automatic send(input logic [15:0] s);
        for (int k = 0; k < 8; k++) begin
            @(posedge core_clk);
            #2;
            phy_ctl = 2'h1;
            phy_d = {s[2*k+1], s[2*k]};
        end
        @(posedge core_clk);
        #2;
        phy_ctl = 2'h0;
        // data lines are meaningless now; never leave the last value
        phy_d = ~phy_d;
    endtask
    // the type lsb decides between 9 and 17 bit frames
    always @(posedge core_clk) begin
        if (n == 5'h0) begin
            // an unknown line before reset counts as idle, never as a start
            sh <= {16'h0, phy_lreq === 1'b1};
            n <= {4'h0, phy_lreq === 1'b1};
        end else begin
            sh <= {sh[15:0], phy_lreq};
            n <= n + 5'h1;
            if (n == 5'h3)
                is_wr <= phy_lreq;
            if (n == (is_wr ? 5'h10 : 5'h8)) begin
                frame <= {sh[15:0], phy_lreq};
                got <= got + 1;
                n <= 5'h0;
            end
        end
    end
endmodule

/* tb/tb.sv */
// self-checking bench for nip_top with a phy model on its pins
// assumes the 20 MHz core clock and the register port of the note
`timescale 1ns/1ps
module tb;
    import nip_pkg::*;
`define CHK(a, e) begin \
    check_count++; \
    if ((a) !== (e)) begin \
        n_errors++; \
        $display("ERROR t=%0t got %h exp %h", $time, a, e); \
    end \
end
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic [7:0] reg_addr = 8'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic [31:0] w32;
    logic [1:0] phy_ctl;
    logic [1:0] phy_d;
    logic phy_lreq;
    logic [15:0] node_id;
    logic node_id_valid;
    logic node_index_none;
    logic [9:0] bus = 10'h3ff;
    logic [5:0] idx = 6'h0;
    logic root = 1'b0;
    logic cable_power_ok = 1'b0;
    logic vld = 1'b0;
    logic [3:0] ri = 4'h0;
    logic [7:0] rv = 8'h0;
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;
    nip_top i_dut (.core_clk(core_clk), .nrst(nrst), .ce(ce),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .phy_ctl(phy_ctl),
        .phy_d(phy_d), .phy_lreq(phy_lreq), .node_id(node_id),
        .node_id_valid(node_id_valid), .node_index_none(node_index_none));
    nip_phy_model i_phy (.core_clk(core_clk), .phy_lreq(phy_lreq),
        .phy_ctl(phy_ctl), .phy_d(phy_d));
    always #25 core_clk = ~core_clk;
    function automatic logic [31:0] pa_exp(logic d, logic [3:0] i,
        logic [7:0] v, logic [3:0] t, logic [7:0] w);
        return {d, 3'h0, i, v, 4'h0, t, w};
    endfunction
    task automatic final_report;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            final_report();
        end
    end
    task automatic wr(logic [7:0] a, logic [31:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge core_clk);
        #2;
        reg_wr = 1'b0;
    endtask
    task automatic chk_rd(logic [7:0] a, logic [31:0] e);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge core_clk);
        #2;
        reg_rd = 1'b0;
        `CHK(reg_rdata, e)
        // one idle edge so a following read never rewrites the strobe
        @(posedge core_clk);
        #2;
    endtask
    task automatic chk_ni;
        chk_rd(8'he8, {vld, root, 2'h0, cable_power_ok, 11'h0, bus, idx});
        `CHK(node_id, {bus, idx})
        `CHK(node_id_valid, vld)
    endtask
    // status pairs carry S0..S15; S2 flags a bus reset
    task automatic status(logic rst, logic [3:0] i, logic [7:0] v);
        logic [15:0] s;
        s = 16'h0;
        s[2] = rst;
        for (int k = 0; k < 4; k++)
            s[4+k] = i[3-k];
        for (int k = 0; k < 8; k++)
            s[8+k] = v[7-k];
        i_phy.send(s);
        repeat (6) @(posedge core_clk);
        #2;
        ri = i;
        rv = v;
        if (i == 4'h0)
            {idx, root, cable_power_ok, vld} = {v, 1'b1};
        if (rst)
            vld = 1'b0;
    endtask
    task automatic req(logic w, logic [3:0] i, logic [7:0] v);
        int g;
        g = i_phy.got;
        wr(8'hec, {16'h0, ~w, w, 2'h0, i, v});
        for (int t = 0; t < 40 && i_phy.got == g; t++) begin
            @(posedge core_clk);
            #2;
        end
        `CHK(i_phy.frame, w ? {1'b1, 3'h5, i, v, 1'b0} : {8'h0, 4'hc, i, 1'b0})
        chk_rd(8'hec, pa_exp(1'b0, ri, rv, i, v));
        status(1'b0, i, 8'($urandom));
        chk_rd(8'hec, pa_exp(1'b1, ri, rv, i, v));
    endtask
    initial begin
        void'($urandom(18753));
        repeat (5) @(posedge core_clk);
        #2;
        nrst = 1'b1;
        chk_ni();
        chk_rd(8'hec, 32'h0);
        chk_rd(8'h40, 32'h0);
        $display("test reset done");
        w32 = $urandom;
        wr(8'he8, w32);
        bus = w32[15:6];
        chk_ni();
        ce = 1'b0;
        wr(8'he8, 32'h0);
        ce = 1'b1;
        chk_ni();
        $display("test bus segment done");
        for (int k = 0; k < 2; k++) begin
            status(1'b0, 4'h0, k ? 8'hff : 8'($urandom));
            chk_ni();
            `CHK(node_index_none, idx == 6'h3f)
            chk_rd(8'hec, pa_exp(1'b1, ri, rv, 4'h0, 8'h0));
            status(1'b1, 4'h3, 8'h5a);
            chk_ni();
        end
        $display("test status done");
        for (int k = 0; k < 6; k++)
            req(k[0], 4'($urandom_range(15, 1)), 8'($urandom));
        $display("test requests done");
        final_report();
    end
endmodule
